// >>> hdl/hpcb_pkg.sv
// Purpose: shared constants and types of the host port and clock/baud configuration block
// Assumes: 8-bit register map, offsets are byte addresses of the host port
// Notes:   clock source bit positions and reset values live here only
package hpcb_pkg;
    localparam logic [7:0] ADDR_FIFO   = 8'h00;
    localparam logic [7:0] ADDR_DIV_LO = 8'h1C;
    localparam logic [7:0] ADDR_DIV_HI = 8'h1D;
    localparam logic [7:0] ADDR_CSRC   = 8'h1E;
    localparam logic [7:0] ADDR_REV    = 8'h1F;
    localparam logic [7:0] ADDR_LAST   = 8'h1F;

    localparam logic [7:0] RST_DIV_LO  = 8'h01;
    localparam logic [7:0] RST_DIV_HI  = 8'h00;
    localparam logic [7:0] RST_CSRC    = 8'h08;
    localparam logic [7:0] CSRC_MASK   = 8'h9F;

    localparam int CSRC_CLK_PIN  = 7;
    localparam int CSRC_EXT_SRC  = 4;
    localparam int CSRC_BYPASS   = 3;
    localparam int CSRC_MUL_EN   = 2;
    localparam int CSRC_XTAL_EN  = 1;
    localparam int CSRC_OSC_EN   = 0;

    localparam int SPI_WRITE_BIT = 7;

    localparam logic [4:0] TPB_16X = 5'h10;
    localparam logic [4:0] TPB_8X  = 5'h08;
    localparam logic [4:0] TPB_4X  = 5'h04;

    localparam logic [7:0] PINS_IDLE = 8'h2C;

    localparam int MCLK_PERIOD_NS   = 40;
    localparam int FM_SCL_PERIOD_NS = 2500;
    localparam int FM_SCL_HALF_CYC  = FM_SCL_PERIOD_NS / 2 / MCLK_PERIOD_NS;
    localparam int EDGE_LATENCY_CYC = 3;

    typedef enum logic [5:0] {
        I2C_IDLE = 6'h01,
        I2C_DEV  = 6'h02,
        I2C_REG  = 6'h04,
        I2C_WR   = 6'h08,
        I2C_RD   = 6'h10,
        I2C_IGN  = 6'h20
    } hpcb_i2c_state_type;
endpackage

// >>> hdl/hpcb_sync.sv
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: i_mclk is the only clock
// Notes:   only the second stage may be read by other logic
`timescale 1ns/1ps
module hpcb_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_chk
        $error("hpcb_sync needs at least one bit");
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta   <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// >>> hdl/hpcb_baud_gen.sv
// Purpose: integer baud divider, 16x, 8x or 4x sample tick, baud clock and per-bit tick
// Assumes: divisor of zero is treated as one
// Notes:   clock output toggles on each sample tick
`timescale 1ns/1ps
module hpcb_baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic [DIV_W-1:0] i_divisor,
    input  wire logic             i_double_rate_select,
    input  wire logic             i_quadruple_rate_select,
    output logic                  o_baud_clk,
    output logic                  o_baud_tick
);
    logic [DIV_W-1:0] cnt;
    logic [4:0]       sub;
    logic             tick;

    if (DIV_W < 2) begin : g_chk
        $error("hpcb_baud_gen divisor too narrow");
    end

    // quadruple wins when both rate select inputs are high
    wire [4:0] ticks_per_bit = i_quadruple_rate_select ? hpcb_pkg::TPB_4X :
                               i_double_rate_select    ? hpcb_pkg::TPB_8X : hpcb_pkg::TPB_16X;
    wire [DIV_W-1:0] last = (i_divisor == '0) ? '0 : i_divisor - 1'b1;
    wire             wrap = (cnt >= last);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cnt         <= '0;
            sub         <= 5'h00;
            tick        <= 1'b0;
            o_baud_clk  <= 1'b0;
            o_baud_tick <= 1'b0;
        end else begin
            cnt         <= wrap ? '0 : cnt + 1'b1;
            tick        <= wrap;
            o_baud_tick <= 1'b0;
            if (tick) begin
                o_baud_clk <= ~o_baud_clk;
                sub        <= (sub >= ticks_per_bit - 5'h01) ? 5'h00 : sub + 5'h01;
                o_baud_tick <= (sub >= ticks_per_bit - 5'h01);
            end
        end
    end

    a_bit_on_tick: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_baud_tick |-> $past(tick) && $changed(o_baud_clk))
        else $error("bit tick not aligned to sample tick");
endmodule

// >>> hdl/hpcb_host_port.sv
// Purpose: SPI or I2C host port with register access, clock source and baud divisor regs
// Assumes: rest of the map (0x00..0x1B) lives outside, reached through the ext port
// Notes:   pins pass two flip-flops; link edges are found by sampling on i_mclk
`timescale 1ns/1ps
module hpcb_host_port #(
    parameter logic [4:0] I2C_ADDR_PREFIX = 5'h13, // arbitrary value
    parameter logic [7:0] REVISION        = 8'h3C  // arbitrary value
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_spi_select,
    input  wire logic        i_spi_sclk,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_mosi,
    output logic             o_spi_miso,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe_n,
    input  wire logic        i_addr_strap_high,
    input  wire logic        i_addr_strap_low,
    input  wire logic        i_rts_flow,
    input  wire logic        i_double_rate_select,
    input  wire logic        i_quadruple_rate_select,
    input  wire logic [7:0]  i_ext_rdata,
    output logic             o_ext_wr,
    output logic             o_ext_rd,
    output logic [7:0]       o_ext_addr,
    output logic [7:0]       o_ext_wdata,
    output logic [15:0]      o_baud_divisor,
    output logic             o_baud_tick,
    output logic             o_request_or_clock_out_pin,
    output logic             o_external_source_sel,
    output logic             o_multiplier_bypass,
    output logic             o_multiplier_enable,
    output logic             o_crystal_osc_enable,
    output logic             o_internal_osc_enable
);
    // twice the sync latency must fit in half a fast-mode clock
    if (hpcb_pkg::FM_SCL_HALF_CYC < 2 * hpcb_pkg::EDGE_LATENCY_CYC) begin : g_chk
        $error("clock too slow for fast-mode I2C");
    end

    function automatic logic [7:0] addr_step(input logic [7:0] a, input logic fixed);
        addr_step = fixed ? a : {3'b000, a[4:0] + 5'h01};
    endfunction

    logic [7:0] pins_s;
    logic       sel_spi_s;
    logic       sclk_s;
    logic       cs_n_s;
    logic       mosi_s;
    logic       scl_s;
    logic       sda_s;
    logic       strap_hi_s;
    logic       strap_lo_s;
    logic       sclk_d;
    logic       scl_d;
    logic       sda_d;
    logic       baud_clk;

    hpcb_sync #(.WIDTH(8), .RESET_VAL(hpcb_pkg::PINS_IDLE)) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async ({i_spi_select, i_spi_sclk, i_spi_cs_n, i_spi_mosi,
                   i_scl, i_sda, i_addr_strap_high, i_addr_strap_low}),
        .o_sync  (pins_s)
    );

    assign {sel_spi_s, sclk_s, cs_n_s, mosi_s, scl_s, sda_s, strap_hi_s, strap_lo_s} = pins_s;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sclk_d <= 1'b0;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            scl_d  <= scl_s;
            sda_d  <= sda_s;
        end
    end

    // port choice follows the select pin level
    wire sclk_rise = sel_spi_s & ~cs_n_s & sclk_s & ~sclk_d;
    wire sclk_fall = sel_spi_s & ~cs_n_s & ~sclk_s & sclk_d;
    wire scl_rise  = ~sel_spi_s & scl_s & ~scl_d;
    wire scl_fall  = ~sel_spi_s & ~scl_s & scl_d;
    wire i2c_start = ~sel_spi_s & scl_s & scl_d & sda_d & ~sda_s;
    wire i2c_stop  = ~sel_spi_s & scl_s & scl_d & ~sda_d & sda_s;

    // ---------------- SPI ----------------
    logic [2:0] spi_cnt;
    logic [7:0] spi_rx;
    logic [7:0] spi_tx;
    logic [7:0] spi_addr;
    logic       spi_have_cmd;
    logic       spi_is_wr;
    logic       spi_fixed;

    wire [7:0] spi_byte    = {spi_rx[6:0], mosi_s};
    wire       spi_done    = sclk_rise & (spi_cnt == 3'h7);
    wire       spi_cmd_ev  = spi_done & ~spi_have_cmd;
    wire       spi_data_ev = spi_done & spi_have_cmd;
    wire       spi_wr_ev   = spi_data_ev & spi_is_wr;
    wire       spi_rd_ev   = spi_data_ev & ~spi_is_wr;
    wire       spi_load    = sclk_fall & (spi_cnt == 3'h0) & spi_have_cmd & ~spi_is_wr;

    logic [7:0] rd_data;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || cs_n_s) begin
            spi_cnt      <= 3'h0;
            spi_rx       <= 8'h00;
            spi_tx       <= 8'h00;
            spi_have_cmd <= 1'b0;
            spi_is_wr    <= 1'b0;
            spi_fixed    <= 1'b0;
            o_spi_miso   <= 1'b0;
        end else begin
            if (sclk_rise) begin
                spi_rx  <= spi_byte;
                spi_cnt <= spi_cnt + 3'h1;
            end
            if (spi_cmd_ev) begin
                spi_have_cmd <= 1'b1;
                spi_is_wr    <= spi_byte[hpcb_pkg::SPI_WRITE_BIT];
                spi_fixed    <= ({3'b000, spi_byte[4:0]} == hpcb_pkg::ADDR_FIFO);
            end
            if (spi_load) begin
                o_spi_miso <= rd_data[7];
                spi_tx     <= {rd_data[6:0], 1'b0};
            end else if (sclk_fall) begin
                o_spi_miso <= spi_tx[7];
                spi_tx     <= {spi_tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            spi_addr <= 8'h00;
        end else if (spi_cmd_ev) begin
            spi_addr <= {3'b000, spi_byte[4:0]};
        end else if (spi_data_ev) begin
            spi_addr <= addr_step(spi_addr, spi_fixed);
        end
    end

    // ---------------- I2C ----------------
    hpcb_pkg::hpcb_i2c_state_type i2c_state;
    logic [3:0] i2c_cnt;
    logic [7:0] i2c_sh;
    logic [7:0] i2c_tx;
    logic [7:0] i2c_addr;
    logic       i2c_fixed;
    logic       i2c_ack_on;

    wire i2c_rx_st  = (i2c_state == hpcb_pkg::I2C_DEV) | (i2c_state == hpcb_pkg::I2C_REG) |
                      (i2c_state == hpcb_pkg::I2C_WR);
    wire dev_match  = (i2c_sh[7:1] == {I2C_ADDR_PREFIX, strap_hi_s, strap_lo_s});
    wire reg_valid  = (i2c_sh <= hpcb_pkg::ADDR_LAST);
    wire i2c_decide = scl_fall & (i2c_cnt == 4'h8) & i2c_rx_st & ~i2c_ack_on;
    wire i2c_ack_ok = ((i2c_state == hpcb_pkg::I2C_DEV) & dev_match) |
                      ((i2c_state == hpcb_pkg::I2C_REG) & reg_valid) |
                      (i2c_state == hpcb_pkg::I2C_WR);
    wire i2c_wr_ev  = i2c_decide & (i2c_state == hpcb_pkg::I2C_WR);
    wire i2c_mack   = scl_rise & (i2c_cnt == 4'h8) & ~i2c_ack_on &
                      (i2c_state == hpcb_pkg::I2C_RD);
    wire i2c_rd_st  = (i2c_state == hpcb_pkg::I2C_RD);

    always_ff @(posedge i_mclk) begin
        o_sda <= 1'b0;
        if (!i_rst_n) begin
            i2c_state  <= hpcb_pkg::I2C_IDLE;
            i2c_cnt    <= 4'h0;
            i2c_sh     <= 8'h00;
            i2c_tx     <= 8'h00;
            i2c_ack_on <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (i2c_start || i2c_stop) begin
            i2c_state  <= i2c_start ? hpcb_pkg::I2C_DEV : hpcb_pkg::I2C_IDLE;
            i2c_cnt    <= 4'h0;
            i2c_ack_on <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            if (scl_rise) begin
                if (i2c_cnt != 4'h8) begin
                    i2c_sh  <= {i2c_sh[6:0], sda_s};
                    i2c_cnt <= i2c_cnt + 4'h1;
                end else if (i2c_ack_on) begin
                    i2c_cnt <= 4'h0;
                end else if (i2c_rd_st) begin
                    // master nack ends the read burst
                    i2c_cnt <= 4'h0;
                    if (sda_s) begin
                        i2c_state <= hpcb_pkg::I2C_IGN;
                    end
                end
            end
            if (i2c_decide) begin
                i2c_ack_on <= i2c_ack_ok;
                o_sda_oe_n <= ~i2c_ack_ok;
                case (i2c_state)
                    hpcb_pkg::I2C_DEV: begin
                        i2c_state <= ~dev_match ? hpcb_pkg::I2C_IGN :
                                     i2c_sh[0] ? hpcb_pkg::I2C_RD : hpcb_pkg::I2C_REG;
                    end
                    hpcb_pkg::I2C_REG: begin
                        i2c_state <= reg_valid ? hpcb_pkg::I2C_WR : hpcb_pkg::I2C_IGN;
                    end
                    default: begin
                        i2c_state <= i2c_state;
                    end
                endcase
            end else if (scl_fall) begin
                if (i2c_ack_on) begin
                    i2c_ack_on <= 1'b0;
                    o_sda_oe_n <= 1'b1;
                end
                if (i2c_rd_st && i2c_cnt == 4'h0) begin
                    o_sda_oe_n <= rd_data[7];
                    i2c_tx     <= {rd_data[6:0], 1'b1};
                end else if (i2c_rd_st) begin
                    o_sda_oe_n <= (i2c_cnt == 4'h8) ? 1'b1 : i2c_tx[7];
                    i2c_tx     <= {i2c_tx[6:0], 1'b1};
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            i2c_addr  <= 8'h00;
            i2c_fixed <= 1'b0;
        end else if (i2c_decide && i2c_state == hpcb_pkg::I2C_REG) begin
            i2c_addr  <= i2c_sh;
            i2c_fixed <= (i2c_sh == hpcb_pkg::ADDR_FIFO);
        end else if (i2c_wr_ev || i2c_mack) begin
            i2c_addr <= addr_step(i2c_addr, i2c_fixed);
        end
    end

    // ---------------- registers ----------------
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [7:0] csrc;

    wire [7:0] cur_addr  = sel_spi_s ? spi_addr : i2c_addr;
    wire [7:0] cur_wdata = spi_wr_ev ? spi_byte : i2c_sh;
    wire       wr_ev     = spi_wr_ev | i2c_wr_ev;
    wire       rd_ev     = spi_rd_ev | i2c_mack;
    wire       ext_sel   = (cur_addr < hpcb_pkg::ADDR_DIV_LO);

    assign rd_data = (o_ext_addr == hpcb_pkg::ADDR_DIV_LO) ? div_lo :
                     (o_ext_addr == hpcb_pkg::ADDR_DIV_HI) ? div_hi :
                     (o_ext_addr == hpcb_pkg::ADDR_CSRC)   ? csrc   :
                     (o_ext_addr == hpcb_pkg::ADDR_REV)    ? REVISION : i_ext_rdata;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            div_lo <= hpcb_pkg::RST_DIV_LO;
            div_hi <= hpcb_pkg::RST_DIV_HI;
            csrc   <= hpcb_pkg::RST_CSRC;
        end else if (wr_ev) begin
            case (cur_addr)
                hpcb_pkg::ADDR_DIV_LO: div_lo <= cur_wdata;
                hpcb_pkg::ADDR_DIV_HI: div_hi <= cur_wdata;
                hpcb_pkg::ADDR_CSRC:   csrc   <= cur_wdata & hpcb_pkg::CSRC_MASK;
                default:               csrc   <= csrc;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_ext_wr    <= 1'b0;
            o_ext_rd    <= 1'b0;
            o_ext_addr  <= 8'h00;
            o_ext_wdata <= 8'h00;
            o_request_or_clock_out_pin <= 1'b0;
        end else begin
            o_ext_wr    <= wr_ev & ext_sel;
            o_ext_rd    <= rd_ev & ext_sel;
            o_ext_addr  <= cur_addr;
            o_ext_wdata <= cur_wdata;
            // baud clock replaces the flow signal on the shared pin
            o_request_or_clock_out_pin <= csrc[hpcb_pkg::CSRC_CLK_PIN] ? baud_clk : i_rts_flow;
        end
    end

    assign o_baud_divisor        = {div_hi, div_lo};
    assign o_external_source_sel = csrc[hpcb_pkg::CSRC_EXT_SRC];
    assign o_multiplier_bypass   = csrc[hpcb_pkg::CSRC_BYPASS];
    assign o_multiplier_enable   = csrc[hpcb_pkg::CSRC_MUL_EN];
    assign o_crystal_osc_enable  = csrc[hpcb_pkg::CSRC_XTAL_EN];
    assign o_internal_osc_enable = csrc[hpcb_pkg::CSRC_OSC_EN];

    // divisor of zero is run as one, the host must not rely on it
    hpcb_baud_gen #(.DIV_W(16)) u_baud (
        .i_mclk                  (i_mclk),
        .i_rst_n                 (i_rst_n),
        .i_divisor               ({div_hi, div_lo}),
        .i_double_rate_select    (i_double_rate_select),
        .i_quadruple_rate_select (i_quadruple_rate_select),
        .o_baud_clk              (baud_clk),
        .o_baud_tick             (o_baud_tick)
    );

    // ---------------- checks ----------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_div_low_field: assert property (
        wr_ev && cur_addr == hpcb_pkg::ADDR_DIV_LO |=> o_baud_divisor[7:0] == $past(cur_wdata))
        else $error("divisor low byte not taken");
    a_div_high_field: assert property (
        wr_ev && cur_addr == hpcb_pkg::ADDR_DIV_HI |=> o_baud_divisor[15:8] == $past(cur_wdata))
        else $error("divisor high byte not taken");
    a_clk_pin_route: assert property (
        csrc[hpcb_pkg::CSRC_CLK_PIN] |=> o_request_or_clock_out_pin == $past(baud_clk))
        else $error("baud clock not on shared pin");
    a_flow_pin_route: assert property (
        !csrc[hpcb_pkg::CSRC_CLK_PIN] |=> o_request_or_clock_out_pin == $past(i_rts_flow))
        else $error("flow signal not on shared pin");
    a_bypass_after_reset: assert property (
        $past(i_rst_n) == 1'b0 |-> o_multiplier_bypass && !o_multiplier_enable)
        else $error("bypass not active after reset");
    a_csrc_unused_zero: assert property (
        wr_ev && cur_addr == hpcb_pkg::ADDR_CSRC |=> csrc == ($past(cur_wdata) & hpcb_pkg::CSRC_MASK))
        else $error("clock source write not masked");
    a_rev_read_only: assert property (
        spi_load && o_ext_addr == hpcb_pkg::ADDR_REV |=>
            o_spi_miso == REVISION[7] && spi_tx == {REVISION[6:0], 1'b0})
        else $error("revision read wrong");
    a_spi_addr_step: assert property (
        spi_data_ev && !spi_fixed |=> spi_addr == {3'b000, $past(spi_addr[4:0]) + 5'h01})
        else $error("burst address did not advance");
    a_spi_fifo_fixed: assert property (
        spi_data_ev && spi_fixed |=> $stable(spi_addr))
        else $error("fifo burst address moved");
    a_i2c_start_take: assert property (
        i2c_start |=> i2c_state == hpcb_pkg::I2C_DEV ##1 o_sda_oe_n)
        else $error("start not taken");
    a_i2c_idle_release: assert property (
        i2c_state == hpcb_pkg::I2C_IDLE |-> o_sda_oe_n)
        else $error("data line pulled while idle");
    a_i2c_reg_nack: assert property (
        i2c_decide && i2c_state == hpcb_pkg::I2C_REG && !reg_valid |=> o_sda_oe_n)
        else $error("invalid register acknowledged");
    a_i2c_sda_on_low: assert property (
        $changed(o_sda_oe_n) |-> $past(scl_fall || i2c_start || i2c_stop))
        else $error("data line changed outside clock low");

    c_spi_burst_write: cover property (spi_wr_ev ##[1:80] spi_wr_ev);
    c_spi_read_load: cover property (spi_load && o_ext_addr == hpcb_pkg::ADDR_CSRC);
    c_i2c_read_ack: cover property (i2c_mack && !sda_s);
    c_i2c_write: cover property (i2c_wr_ev);
endmodule

// >>> verif/hpcb_host_model.sv
// Purpose: host controller, SPI mode 0 master and I2C master
// Assumes: driven on falling edges of i_mclk
// Notes:   o_sda is released as 1, the bench resolves the wire
`timescale 1ns/1ps
module hpcb_host_model (
    input  wire logic i_mclk,
    input  wire logic i_miso,
    input  wire logic i_sda,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_mosi,
    output logic      o_scl,
    output logic      o_sda
);
    // sclk idles low, bus lines rest released
    initial begin
        {o_sclk, o_cs_n, o_mosi, o_scl, o_sda} = 5'b01011;
    end
    task automatic cs(input logic v);
        o_cs_n = v;
    endtask
    task automatic hw(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // data set before the rise, miso taken at the rise
    task automatic spi(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            o_mosi = tx[b];
            hw(4);
            o_sclk = 1'b1;
            rx[b] = i_miso;
            hw(4);
            o_sclk = 1'b0;
        end
    endtask
    // sda moves mid low phase only, 9th bit is the ack slot
    task automatic i2c(input logic [8:0] tx, output logic [8:0] rx);
        for (int b = 8; b >= 0; b--) begin
            hw(16);
            o_sda = tx[b];
            hw(16);
            o_scl = 1'b1;
            hw(32);
            rx[b] = i_sda;
            o_scl = 1'b0;
        end
    endtask
    // 1 gives start or repeated start, 0 gives stop
    task automatic cond(input logic s);
        hw(16);
        o_sda = s;
        hw(16);
        o_scl = 1'b1;
        hw(16);
        o_sda = ~s;
        hw(16);
        if (s) o_scl = 1'b0;
    endtask
endmodule

// >>> verif/hpcb_host_port_tb_top.sv
// Purpose: self-checking bench of the host port
// Assumes: default host model timing, I2C near 390 kHz
// Notes:   external map answers with the inverted address
`timescale 1ns/1ps
module hpcb_host_port_tb_top;
    logic i_mclk, i_rst_n, i_spi_select, i_addr_strap_high, i_addr_strap_low, i_rts_flow;
    logic i_double_rate_select, i_quadruple_rate_select;
    wire logic i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_scl, m_sda, o_spi_miso, o_sda;
    wire logic o_sda_oe_n, o_ext_wr, o_ext_rd, o_baud_tick, o_request_or_clock_out_pin;
    wire logic o_external_source_sel, o_multiplier_bypass, o_multiplier_enable;
    wire logic o_crystal_osc_enable, o_internal_osc_enable;
    wire logic [7:0] o_ext_addr, o_ext_wdata, i_ext_rdata;
    wire logic [15:0] o_baud_divisor;
    wire logic i_sda = m_sda & (o_sda_oe_n | o_sda);
    int errors = 0, checks_done = 0, wr_cnt = 0, rd_cnt = 0, tk = 0, t0;
    logic [7:0] r, wd;
    logic [8:0] q;
    assign i_ext_rdata = ~o_ext_addr;
    always #20 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        wr_cnt <= wr_cnt + (o_ext_wr === 1'b1);
        tk <= tk + (o_baud_tick === 1'b1);
        rd_cnt <= rd_cnt + (o_ext_rd === 1'b1);
        if (o_ext_wr === 1'b1) wd <= o_ext_wdata;
    end
    hpcb_host_port #(.I2C_ADDR_PREFIX(5'h0E), .REVISION(8'h3C)) DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_spi_select(i_spi_select),
        .i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi),
        .o_spi_miso(o_spi_miso), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n), .i_addr_strap_high(i_addr_strap_high),
        .i_addr_strap_low(i_addr_strap_low), .i_rts_flow(i_rts_flow),
        .i_double_rate_select(i_double_rate_select),
        .i_quadruple_rate_select(i_quadruple_rate_select), .i_ext_rdata(i_ext_rdata),
        .o_ext_wr(o_ext_wr), .o_ext_rd(o_ext_rd), .o_ext_addr(o_ext_addr),
        .o_ext_wdata(o_ext_wdata), .o_baud_divisor(o_baud_divisor), .o_baud_tick(o_baud_tick),
        .o_request_or_clock_out_pin(o_request_or_clock_out_pin),
        .o_external_source_sel(o_external_source_sel),
        .o_multiplier_bypass(o_multiplier_bypass), .o_multiplier_enable(o_multiplier_enable),
        .o_crystal_osc_enable(o_crystal_osc_enable),
        .o_internal_osc_enable(o_internal_osc_enable));
    hpcb_host_model HM (.i_mclk(i_mclk), .i_miso(o_spi_miso), .i_sda(i_sda),
        .o_sclk(i_spi_sclk), .o_cs_n(i_spi_cs_n), .o_mosi(i_spi_mosi), .o_scl(i_scl),
        .o_sda(m_sda));
    task automatic chk(input string n, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic sx(input logic [7:0] c, d, e, input int n);
        HM.cs(1'b0);
        HM.hw(4);
        HM.spi(c, r);
        HM.spi(d, r);
        if (n > 1) HM.spi(e, r);
        HM.hw(8);
        HM.cs(1'b1);
        HM.hw(8);
    endtask
    task automatic ib(input logic [7:0] b, input logic ack);
        HM.i2c({b, 1'b1}, q);
        chk("ack", !ack, q[0]);
    endtask
    task automatic t_spi;
        chk("rst div", 16'h0001, o_baud_divisor);
        chk("rst bypass", 1, o_multiplier_bypass);
        sx(8'h9C, 8'h34, 8'h12, 2);
        chk("div", 16'h1234, o_baud_divisor);
        sx(8'h80, 8'h11, 8'h22, 2);
        chk("fifo wr", 2, wr_cnt);
        chk("fifo addr", 0, o_ext_addr);
        chk("fifo data", 8'h22, wd);
        sx(8'h9F, 8'h00, 0, 1);
        sx(8'h1F, 0, 0, 1);
        chk("rev", 8'h3C, r);
        $display("spi test done");
    endtask
    task automatic t_csrc;
        sx(8'h9E, 8'hFF, 0, 1);
        chk("csrc pins", 5'h1F, {o_external_source_sel, o_multiplier_bypass,
            o_multiplier_enable, o_crystal_osc_enable, o_internal_osc_enable});
        sx(8'h1E, 0, 0, 1);
        chk("csrc", 8'h9F, r);
        sx(8'h9C, 8'h04, 8'h00, 2);
        i_rts_flow = 1'b1;
        t0 = 0;
        repeat (32) begin
            @(negedge i_mclk);
            t0 += !o_request_or_clock_out_pin;
        end
        chk("clk lows", 16, t0);
        for (int m = 0; m < 3; m++) begin
            {i_quadruple_rate_select, i_double_rate_select} = m;
            HM.hw(80);
            t0 = tk;
            HM.hw(256);
            chk("ticks", 4 << m, tk - t0);
        end
        sx(8'h9E, 8'h08, 0, 1);
        chk("rts pin", 1, o_request_or_clock_out_pin);
        $display("clock test done");
    endtask
    task automatic t_i2c;
        i_spi_select = 1'b0;
        HM.hw(8);
        HM.cond(1);
        ib(8'h74, 1);
        ib(8'h1C, 1);
        ib(8'h56, 1);
        HM.cond(0);
        chk("i2c div", 16'h0056, o_baud_divisor);
        HM.cond(1);
        ib(8'h74, 1);
        ib(8'h1F, 1);
        HM.cond(1);
        ib(8'h75, 1);
        HM.i2c(9'h1FE, q);
        chk("i2c rev", 8'h3C, q[8:1]);
        HM.i2c(9'h1FE, q);
        chk("i2c wrap", 8'hFF, q[8:1]);
        HM.i2c(9'h1FF, q);
        chk("i2c ext", 8'hFE, q[8:1]);
        chk("ext rd", 2, rd_cnt);
        HM.cond(0);
        HM.cond(1);
        ib(8'h76, 0);
        HM.cond(0);
        {i_addr_strap_high, i_addr_strap_low} = 2'b01;
        HM.cond(1);
        ib(8'h72, 1);
        ib(8'h20, 0);
        HM.cond(0);
        $display("i2c test done");
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {i_mclk, i_rst_n, i_spi_select, i_rts_flow} = 4'b0010;
        {i_addr_strap_high, i_addr_strap_low} = 2'b10;
        {i_double_rate_select, i_quadruple_rate_select} = 2'b00;
        repeat (8) @(negedge i_mclk);
        i_rst_n = 1'b1;
        HM.hw(4);
        t_spi;
        t_csrc;
        t_i2c;
        end_sim;
    end
    initial begin
        #2ms;
        errors++;
        end_sim;
    end
endmodule
